// ===== hdl/cpf_forward.sv
// Purpose: frame forwarding ring of a slave_frame_controller with up to four ports
// Assumes: link status pins are asynchronous; frame streams are on sys_clk
// Notes:   processing unit is outside; it sees frames via proc_in/proc_out
`timescale 1ns/10ps

module cpf_forward
    import cpf_pkg::*;
#(
    parameter int NUM_PORTS = CPF_NUM_PORTS
) (
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire cpf_beat_t       rx_beat [3],
    output cpf_beat_t            tx_beat [3],
    input  wire logic [2:0]      link_up,
    output cpf_beat_t            proc_in,
    input  wire cpf_beat_t       proc_out,
    input  wire logic            cyclic_enable,
    input  wire logic            ref_candidate,
    input  wire logic [63:0]     local_time,
    output logic                 ref_clock_active,
    output logic [63:0]          ref_time,
    output logic [2:0]           port_open
);

    logic [2:0]     sync1_q, sync1_d;
    logic [2:0]     sync2_q, sync2_d;
    logic [2:0]     sync3_q, sync3_d;
    logic [2:0]     open_q, open_d;
    cpf_beat_t      tx_q [3];
    cpf_beat_t      tx_d [3];
    cpf_beat_t      proc_q, proc_d;
    cpf_beat_t      to_down, to_up;
    cpf_ref_state_t ref_q, ref_d;
    logic [63:0]    rtime_q, rtime_d;

    localparam cpf_beat_t IDLE = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: CPF_RST_DATA};

    // link synchronisers: a change counts when stages two and three agree
    always_comb begin
        sync1_d = link_up;
        sync2_d = sync1_q;
        sync3_d = sync2_q;
        open_d  = open_q;
        // ports NUM_PORTS - 1 and above stay closed; more than four ports is not supported
        for (int i = 0; i < NUM_PORTS - 1; i++) begin
            if (sync2_q[i] == sync3_q[i]) begin
                open_d[i] = sync3_q[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1_q <= CPF_RST_SYNC;
            sync2_q <= CPF_RST_SYNC;
            sync3_q <= CPF_RST_SYNC;
            open_q  <= CPF_RST_SYNC;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sync3_q <= sync3_d;
            open_q  <= open_d;
        end
    end

    // forwarding ring 0 -> 3(proc) -> 1 -> 2 -> 0, closed ports 1 and 2 looped
    always_comb begin
        proc_d = rx_beat[0];
        // port 1 closed: processed datagram goes on to port 2
        if (open_q[1]) begin
            tx_d[1] = proc_out;
            to_down = rx_beat[1];
        end else begin
            tx_d[1] = IDLE;
            to_down = proc_out;
        end
        if (open_q[2]) begin
            tx_d[2] = to_down;
            to_up   = rx_beat[2];
        end else begin
            tx_d[2] = IDLE;
            to_up   = to_down;
        end
        tx_d[0] = open_q[0] ? to_up : IDLE;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            proc_q <= IDLE;
            for (int i = 0; i < 3; i++) begin
                tx_q[i] <= IDLE;
            end
        end else begin
            proc_q <= proc_d;
            for (int i = 0; i < 3; i++) begin
                tx_q[i] <= tx_d[i];
            end
        end
    end

    // reference clock role
    always_comb begin
        ref_d   = (cyclic_enable && ref_candidate) ? CPF_REF_ACTIVE : CPF_REF_OFF;
        rtime_d = (ref_q == CPF_REF_ACTIVE) ? local_time : rtime_q;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ref_q   <= CPF_REF_OFF;
            rtime_q <= CPF_RST_TIME;
        end else begin
            ref_q   <= ref_d;
            rtime_q <= rtime_d;
        end
    end

    assign tx_beat          = tx_q;
    assign proc_in          = proc_q;
    assign port_open        = open_q;
    assign ref_clock_active = (ref_q == CPF_REF_ACTIVE);
    assign ref_time         = rtime_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_rx0_to_proc;
        rx_beat[0].valid |=> proc_in.valid && proc_in.data == $past(rx_beat[0].data);
    endproperty
    a_rx0_to_proc: assert property (p_rx0_to_proc) else $error("port 0 beat not sent to processing");

    property p_proc_to_p1;
        open_q[1] && proc_out.valid |=> tx_beat[1].valid && tx_beat[1].data == $past(proc_out.data);
    endproperty
    a_proc_to_p1: assert property (p_proc_to_p1) else $error("processed beat not on port 1");

    property p_p1_closed_quiet;
        !open_q[1] |=> !tx_beat[1].valid;
    endproperty
    a_p1_closed_quiet: assert property (p_p1_closed_quiet) else $error("closed port 1 transmitted");

    property p_p1_to_p2;
        open_q[1] && open_q[2] && rx_beat[1].valid |=> tx_beat[2].valid && tx_beat[2].data == $past(rx_beat[1].data);
    endproperty
    a_p1_to_p2: assert property (p_p1_to_p2) else $error("port 1 return not on port 2");

    property p_p2_to_p0;
        open_q[2] && open_q[0] && rx_beat[2].valid |=> tx_beat[0].valid && tx_beat[0].data == $past(rx_beat[2].data);
    endproperty
    a_p2_to_p0: assert property (p_p2_to_p0) else $error("port 2 return not on port 0");

    property p_loop_p2;
        !open_q[2] && open_q[1] && open_q[0] && rx_beat[1].valid
            |=> tx_beat[0].valid && tx_beat[0].data == $past(rx_beat[1].data);
    endproperty
    a_loop_p2: assert property (p_loop_p2) else $error("closed port 2 not looped");

    property p_unaltered;
        open_q == 3'h7 && rx_beat[2].valid |=> tx_beat[0] == $past(rx_beat[2]);
    endproperty
    a_unaltered: assert property (p_unaltered) else $error("frame altered off processing path");

    property p_ref_needs_both;
        ref_clock_active |-> $past(cyclic_enable) && $past(ref_candidate);
    endproperty
    a_ref_needs_both: assert property (p_ref_needs_both) else $error("reference active without settings");

    property p_ref_time;
        ref_clock_active |=> ref_time == $past(local_time);
    endproperty
    a_ref_time: assert property (p_ref_time) else $error("reference time not local time");

    property p_link_settle;
        $rose(link_up[1]) ##1 link_up[1] [*3] |=> open_q[1];
    endproperty
    a_link_settle: assert property (p_link_settle) else $error("port 1 link not taken");

    property p_link_drop;
        $fell(link_up[1]) ##1 !link_up[1] [*3] |=> !open_q[1];
    endproperty
    a_link_drop: assert property (p_link_drop) else $error("port 1 link loss not taken");

    property p_proc_marks;
        rx_beat[0].valid |=> proc_in.sof == $past(rx_beat[0].sof) && proc_in.eof == $past(rx_beat[0].eof);
    endproperty
    a_proc_marks: assert property (p_proc_marks) else $error("frame marks lost towards processing");

    property p_p1_loop_to_p2;
        !open_q[1] && open_q[2] && proc_out.valid |=> tx_beat[2].valid && tx_beat[2].data == $past(proc_out.data);
    endproperty
    a_p1_loop_to_p2: assert property (p_p1_loop_to_p2) else $error("closed port 1 not looped to port 2");

    property p_p2_closed_quiet;
        !open_q[2] |=> !tx_beat[2].valid;
    endproperty
    a_p2_closed_quiet: assert property (p_p2_closed_quiet) else $error("closed port 2 transmitted");

    property p_p0_closed_quiet;
        !open_q[0] |=> !tx_beat[0].valid;
    endproperty
    a_p0_closed_quiet: assert property (p_p0_closed_quiet) else $error("closed port 0 transmitted");

    property p_ref_off;
        !(cyclic_enable && ref_candidate) |=> !ref_clock_active;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("reference kept without both settings");

    property p_ref_hold;
        !ref_clock_active |=> $stable(ref_time);
    endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("reference time moved while inactive");

    c_full_ring:  cover property (open_q == 3'h7 && rx_beat[2].valid);
    c_p1_closed:  cover property (!open_q[1] && proc_out.valid);
    c_ref_active: cover property ($rose(ref_clock_active));
    c_p2_closed:  cover property (!open_q[2] && open_q[1] && rx_beat[1].valid);
    c_ref_drop:   cover property ($fell(ref_clock_active));

endmodule // cpf_forward

// ===== hdl/cpf_pkg.sv
// Purpose: shared types and constants for the coupler port frame forwarding block
// Assumes: byte-wide frame streams, one byte per cycle per port
// Notes:   port numbering 0..3, port 3 internal and closed

package cpf_pkg;

    localparam int CPF_NUM_PORTS   = 4;
    localparam int CPF_DATA_W      = 8;
    localparam int CPF_SYNC_STAGES = 3;
    localparam logic [1:0] CPF_PORT_UP    = 2'h0;
    localparam logic [1:0] CPF_PORT_CHAIN = 2'h1;
    localparam logic [1:0] CPF_PORT_DOWN  = 2'h2;
    localparam logic [1:0] CPF_PORT_PROC  = 2'h3;
    localparam logic [7:0] CPF_RST_DATA   = 8'h00;
    localparam logic [2:0] CPF_RST_SYNC   = 3'h0;
    localparam logic [63:0] CPF_RST_TIME  = 64'h0;

    // one byte lane of a frame stream
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic [7:0] data;
    } cpf_beat_t;

    typedef enum logic [1:0] {
        CPF_REF_OFF    = 2'b00,
        CPF_REF_ACTIVE = 2'b01
    } cpf_ref_state_t;

endpackage

// ===== testbench/cpf_forward_tb.sv
// Purpose: self-checking bench for the frame forwarding ring
// Assumes: link held stable long enough to settle before traffic is checked
// Notes:   random beats on all ports, every link combination first
`timescale 1ns/10ps

module cpf_forward_tb
    import cpf_pkg::*;
;
    logic        sys_clk, rst_n, cyc, cand, ract;
    cpf_beat_t   rx [3];
    cpf_beat_t   tx [3];
    cpf_beat_t   pin, pout, q0, q1, q2, qp, e0, e1, e2;
    logic [2:0]  link, popen;
    logic [63:0] lt, qlt, rtime, held;
    int          mismatches, n_tests;
    int          cycles = 0;

    cpf_forward #(.NUM_PORTS(CPF_NUM_PORTS)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .rx_beat(rx), .tx_beat(tx),
        .link_up(link), .proc_in(pin), .proc_out(pout), .cyclic_enable(cyc), .ref_candidate(cand),
        .local_time(lt), .ref_clock_active(ract), .ref_time(rtime), .port_open(popen));
    cpf_partner u_partner (.sys_clk(sys_clk), .rst_n(rst_n), .proc_in(pin), .proc_out(pout));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic cmp_beat(input cpf_beat_t seen, input cpf_beat_t exp);
        if (exp.valid) begin
            chk(64'(seen), 64'(exp));
        end else begin
            chk(64'(seen.valid), 64'h0);
        end
    endtask

    function automatic void route(input logic [2:0] o, input cpf_beat_t pr, input cpf_beat_t r1,
                                  input cpf_beat_t r2, output cpf_beat_t t0, output cpf_beat_t t1,
                                  output cpf_beat_t t2);
        cpf_beat_t s2;
        cpf_beat_t s0;
        s2 = o[1] ? r1 : pr;
        s0 = o[2] ? r2 : s2;
        t1 = o[1] ? pr : '0;
        t2 = o[2] ? s2 : '0;
        t0 = o[0] ? s0 : '0;
    endfunction

    always @(posedge sys_clk) begin
        q0 <= rx[0];
        q1 <= rx[1];
        q2 <= rx[2];
        qp <= pout;
        qlt <= lt;
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        rst_n = 1'b0;
        link = 3'h0;
        cyc = 1'b0;
        cand = 1'b0;
        lt = 64'h0;
        foreach (rx[i]) rx[i] = '0;
        mismatches = 0;
        n_tests = 0;
        void'($urandom(25));
        repeat (16) @(negedge sys_clk);
        chk(64'(popen), 64'h0);
        chk(64'(ract), 64'h0);
        chk(64'(tx[1].valid), 64'h0);
        rst_n = 1'b1;
        for (int k = 0; k < 24; k++) begin
            link = (k < 8) ? k[2:0] : 3'($urandom);
            {cyc, cand} = (k == 7 || k == 15) ? 2'h3 : 2'($urandom);
            repeat (8) @(negedge sys_clk);
            chk(64'(popen), 64'(link));
            held = rtime;
            repeat (20) begin
                @(negedge sys_clk);
                route(link, qp, q1, q2, e0, e1, e2);
                cmp_beat(tx[1], e1);
                cmp_beat(tx[2], e2);
                cmp_beat(tx[0], e0);
                cmp_beat(pin, q0);
                chk(64'(ract), 64'(cyc & cand));
                chk(rtime, (cyc & cand) ? qlt : held);
                foreach (rx[i]) rx[i] = cpf_beat_t'($urandom);
                lt = {$urandom, $urandom};
            end
        end
        wrap_up();
    end
endmodule // cpf_forward_tb

// ===== testbench/cpf_partner.sv
// Purpose: processing unit model on the port 0 to port 1 path
// Assumes: one cycle turnaround on sys_clk
// Notes:   data inverted to show processing; idle data keeps changing
`timescale 1ns/10ps

module cpf_partner
    import cpf_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire logic      rst_n,
    input  wire cpf_beat_t proc_in,
    output cpf_beat_t      proc_out
);
    cpf_beat_t out_q;
    cpf_beat_t out_d;

    always_comb begin
        out_d = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: out_q.data + 8'h01};
        if (proc_in.valid) begin
            out_d = '{valid: 1'b1, sof: proc_in.sof, eof: proc_in.eof, data: ~proc_in.data};
        end
    end

    always_ff @(posedge sys_clk) begin
        out_q <= rst_n ? out_d : '0;
    end

    assign proc_out = out_q;
endmodule // cpf_partner
